//--- src/ifep_pkg.sv
package ifep_pkg;
    // Special-function register addresses
    localparam logic [7:0] ADDR_EXT_FLAG = 8'h91;
    localparam logic [7:0] ADDR_BASE_ENABLE = 8'hA8;
    localparam logic [7:0] ADDR_BASE_LEVEL = 8'hB8;
    localparam logic [7:0] ADDR_WAKE_CTRL = 8'hD8;
    localparam logic [7:0] ADDR_EXT_ENABLE = 8'hE8;
    localparam logic [7:0] ADDR_EXT_LEVEL = 8'hF8;
    // Field positions
    localparam int GLOBAL_MASK_POS = 7;
    localparam int WAKE_FLAG_POS = 3;
    // Writable masks and fixed read values
    localparam logic [7:0] BASE_ENABLE_WMASK = 8'hBF;
    localparam logic [7:0] BASE_LEVEL_WMASK = 8'h3F;
    localparam logic [7:0] BASE_LEVEL_FIXED = 8'h80;
    localparam logic [7:0] EXT_FLAG_WMASK = 8'hF0;
    localparam logic [7:0] EXT_FLAG_FIXED = 8'h08;
    localparam logic [7:0] WAKE_CTRL_WMASK = 8'h88;
    localparam logic [7:0] WAKE_CTRL_FIXED = 8'h40;
    localparam logic [7:0] EXT_WMASK = 8'h1F;
    localparam logic [7:0] EXT_FIXED = 8'hE0;
    // Reset values
    localparam logic [7:0] BASE_ENABLE_RST = 8'h00;
    localparam logic [7:0] BASE_LEVEL_RST = 8'h00;
    localparam logic [7:0] EXT_FLAG_RST = 8'h00;
    localparam logic [7:0] WAKE_CTRL_RST = 8'h00;
    localparam logic [7:0] EXT_ENABLE_RST = 8'h00;
    localparam logic [7:0] EXT_LEVEL_RST = 8'h00;
    // Source count and vectors, natural order index 0..10
    localparam int NUM_SRC = 11;
    localparam logic [7:0] VEC_BASE = 8'h03;
    localparam logic [7:0] VEC_STEP = 8'h08;
    localparam logic [7:0] VEC_EXT_BASE = 8'h43;
    localparam int EXT_FIRST = 6;
endpackage

//--- src/ifep_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - Base enable bit 7 masks all; when 1 each source uses its enable.
// - Base enable bit 5 gates timer 2 overflow or external flag.
// - Base enable bit 4 gates serial transmit-done or receive-done.
// - Base enable bits 3 and 1 gate timer 1 and timer 0 overflow.
// - Base enable bits 2 and 0 gate external pin 1 and pin 0.
// - Base level bits 5..0 pick high or low level per base source.
// - Reserved bits read back their fixed ones and zeros.
// - Address-match rising edge sets extended flag bit 7.
// - Data-ready rising edge sets extended flag bit 6.
// - Serial-peripheral byte done sets extended flag bit 5.
// - End-of-conversion rising edge sets extended flag bit 4.
// - Hardware never clears extended flags; software does.
// - A wakeup event sets wakeup control bit 3.
// - Software writing a flag to 1 raises the interrupt like hardware.
// - A wakeup flag left set keeps requesting the interrupt.
// - Extended enable bits 4..0 gate wakeup, match, ready, shift, conversion.
// - Extended level bits 4..0 pick level for those same sources.
// - Extended sources vector to 0x43, 4B, 53, 5B, 63.
// - Higher level wins, then natural order from external pin 0 down.
module ifep_ctrl
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register port from the core
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_wr,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // Base source flags, held by their own units
    input wire logic i_ext_pin0_flag,
    input wire logic i_timer0_overflow,
    input wire logic i_ext_pin1_flag,
    input wire logic i_timer1_overflow,
    input wire logic i_uart_tx_done,
    input wire logic i_uart_rx_done,
    input wire logic i_timer2_overflow,
    input wire logic i_timer2_external_flag,
    // Extended event sources
    input wire logic i_conversion_end,
    input wire logic i_shift_done,
    input wire logic i_radio_payload_ready,
    input wire logic i_radio_addr_match,
    input wire logic i_wake_event,
    // Request to the core
    output logic o_irq_req,
    output logic o_irq_high,
    output logic [3:0] o_irq_src,
    output logic [7:0] o_irq_vector
);
    logic [7:0] base_enable_reg;
    logic [7:0] base_level_reg;
    logic [7:0] extended_flag_reg;
    logic [7:0] wake_control_reg;
    logic [7:0] extended_enable_reg;
    logic [7:0] extended_level_reg;
    logic [7:0] next_extended_flag;
    logic [7:0] next_wake_control;
    logic conv_q;
    logic payload_q;
    logic match_q;

    // Address decode
    wire wr_base_en = i_sfr_wr && (i_sfr_addr == ifep_pkg::ADDR_BASE_ENABLE);
    wire wr_base_lv = i_sfr_wr && (i_sfr_addr == ifep_pkg::ADDR_BASE_LEVEL);
    wire wr_ext_flag = i_sfr_wr && (i_sfr_addr == ifep_pkg::ADDR_EXT_FLAG);
    wire wr_wake = i_sfr_wr && (i_sfr_addr == ifep_pkg::ADDR_WAKE_CTRL);
    wire wr_ext_en = i_sfr_wr && (i_sfr_addr == ifep_pkg::ADDR_EXT_ENABLE);
    wire wr_ext_lv = i_sfr_wr && (i_sfr_addr == ifep_pkg::ADDR_EXT_LEVEL);

    // Edge detection; the shift-done strobe is already a one-cycle event
    wire conv_rise = i_conversion_end && !conv_q;
    wire payload_rise = i_radio_payload_ready && !payload_q;
    wire match_rise = i_radio_addr_match && !match_q;
    wire [7:0] hw_set = {match_rise, payload_rise, i_shift_done, conv_rise, 4'h0};

    // Software write lands first, hardware sets are ORed on top so they win
    wire [7:0] flag_sw = wr_ext_flag ? (i_sfr_wdata & ifep_pkg::EXT_FLAG_WMASK) : extended_flag_reg;
    wire [7:0] wake_sw = wr_wake ? (i_sfr_wdata & ifep_pkg::WAKE_CTRL_WMASK) : wake_control_reg;
    wire [7:0] wake_set = {4'h0, i_wake_event, 3'h0};

    always_comb
    begin
        next_extended_flag = flag_sw | hw_set;
        next_wake_control = wake_sw | wake_set;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            conv_q <= 1'b0;
            payload_q <= 1'b0;
            match_q <= 1'b0;
            extended_flag_reg <= ifep_pkg::EXT_FLAG_RST;
            wake_control_reg <= ifep_pkg::WAKE_CTRL_RST;
        end
        else
        begin
            conv_q <= i_conversion_end;
            payload_q <= i_radio_payload_ready;
            match_q <= i_radio_addr_match;
            extended_flag_reg <= next_extended_flag;
            wake_control_reg <= next_wake_control;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            base_enable_reg <= ifep_pkg::BASE_ENABLE_RST;
            base_level_reg <= ifep_pkg::BASE_LEVEL_RST;
            extended_enable_reg <= ifep_pkg::EXT_ENABLE_RST;
            extended_level_reg <= ifep_pkg::EXT_LEVEL_RST;
        end
        else
        begin
            if (wr_base_en)
                base_enable_reg <= i_sfr_wdata & ifep_pkg::BASE_ENABLE_WMASK;
            if (wr_base_lv)
                base_level_reg <= i_sfr_wdata & ifep_pkg::BASE_LEVEL_WMASK;
            if (wr_ext_en)
                extended_enable_reg <= i_sfr_wdata & ifep_pkg::EXT_WMASK;
            if (wr_ext_lv)
                extended_level_reg <= i_sfr_wdata & ifep_pkg::EXT_WMASK;
        end
    end

    // Read mux with fixed reserved bits
    wire [7:0] rd_base_lv = base_level_reg | ifep_pkg::BASE_LEVEL_FIXED;
    wire [7:0] rd_ext_flag = extended_flag_reg | ifep_pkg::EXT_FLAG_FIXED;
    wire [7:0] rd_wake = wake_control_reg | ifep_pkg::WAKE_CTRL_FIXED;
    wire [7:0] rd_ext_en = extended_enable_reg | ifep_pkg::EXT_FIXED;
    wire [7:0] rd_ext_lv = extended_level_reg | ifep_pkg::EXT_FIXED;

    always_comb
    begin
        o_sfr_hit = 1'b1;
        case (i_sfr_addr)
            ifep_pkg::ADDR_BASE_ENABLE: o_sfr_rdata = base_enable_reg;
            ifep_pkg::ADDR_BASE_LEVEL: o_sfr_rdata = rd_base_lv;
            ifep_pkg::ADDR_EXT_FLAG: o_sfr_rdata = rd_ext_flag;
            ifep_pkg::ADDR_WAKE_CTRL: o_sfr_rdata = rd_wake;
            ifep_pkg::ADDR_EXT_ENABLE: o_sfr_rdata = rd_ext_en;
            ifep_pkg::ADDR_EXT_LEVEL: o_sfr_rdata = rd_ext_lv;
            default:
            begin
                o_sfr_rdata = 8'h00;
                o_sfr_hit = 1'b0;
            end
        endcase
    end

    // Named fields of the enable and level registers
    wire global_mask_bit = base_enable_reg[ifep_pkg::GLOBAL_MASK_POS];
    wire pin0_irq_enable = base_enable_reg[0];
    wire timer0_irq_enable = base_enable_reg[1];
    wire pin1_irq_enable = base_enable_reg[2];
    wire timer1_irq_enable = base_enable_reg[3];
    wire uart_irq_enable = base_enable_reg[4];
    wire timer2_irq_enable = base_enable_reg[5];
    wire pin0_irq_level = base_level_reg[0];
    wire timer0_irq_level = base_level_reg[1];
    wire pin1_irq_level = base_level_reg[2];
    wire timer1_irq_level = base_level_reg[3];
    wire uart_irq_level = base_level_reg[4];
    wire timer2_irq_level = base_level_reg[5];
    wire conversion_irq_enable = extended_enable_reg[0];
    wire shift_irq_enable = extended_enable_reg[1];
    wire payload_irq_enable = extended_enable_reg[2];
    wire match_irq_enable = extended_enable_reg[3];
    wire wake_irq_enable = extended_enable_reg[4];
    wire conversion_irq_level = extended_level_reg[0];
    wire shift_irq_level = extended_level_reg[1];
    wire payload_irq_level = extended_level_reg[2];
    wire match_irq_level = extended_level_reg[3];
    wire wake_irq_level = extended_level_reg[4];
    // Flag fields; base flags stay in their own units and are not latched here
    wire conversion_done_flag = extended_flag_reg[4];
    wire shift_done_flag = extended_flag_reg[5];
    wire payload_ready_flag = extended_flag_reg[6];
    wire addr_match_flag = extended_flag_reg[7];
    wire wake_flag = wake_control_reg[ifep_pkg::WAKE_FLAG_POS];

    // Pending vector in natural order, index 0 = external pin 0
    wire global_on = global_mask_bit;
    wire [10:0] src_flag = {
        wake_flag,
        addr_match_flag,
        payload_ready_flag,
        shift_done_flag,
        conversion_done_flag,
        i_timer2_overflow | i_timer2_external_flag,
        i_uart_tx_done | i_uart_rx_done,
        i_timer1_overflow,
        i_ext_pin1_flag,
        i_timer0_overflow,
        i_ext_pin0_flag};
    // Base enable order is pin0,t0,pin1,t1,uart,t2 = bits 0..5, extended bits 0..4 follow
    wire [10:0] src_enable = {
        wake_irq_enable,
        match_irq_enable,
        payload_irq_enable,
        shift_irq_enable,
        conversion_irq_enable,
        timer2_irq_enable,
        uart_irq_enable,
        timer1_irq_enable,
        pin1_irq_enable,
        timer0_irq_enable,
        pin0_irq_enable};
    wire [10:0] src_level = {
        wake_irq_level,
        match_irq_level,
        payload_irq_level,
        shift_irq_level,
        conversion_irq_level,
        timer2_irq_level,
        uart_irq_level,
        timer1_irq_level,
        pin1_irq_level,
        timer0_irq_level,
        pin0_irq_level};
    wire [10:0] pending = src_flag & src_enable & {11{global_on}};
    wire [10:0] pend_high = pending & src_level;
    wire any_high = |pend_high;
    wire [10:0] contest = any_high ? pend_high : pending;

    logic [3:0] win_idx;
    always_comb
    begin
        win_idx = 4'h0;
        for (int i = ifep_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (contest[i])
                win_idx = 4'(i);
        end
    end

    // Vector: base at 0x03 step 8; extended sit after a gap at 0x43
    wire is_ext = (win_idx >= 4'(ifep_pkg::EXT_FIRST));
    wire [7:0] ext_vec = ifep_pkg::VEC_EXT_BASE + 8'({win_idx - 4'(ifep_pkg::EXT_FIRST), 3'h0});
    wire [7:0] base_vec = ifep_pkg::VEC_BASE + 8'({win_idx, 3'h0});

    always_comb
    begin
        o_irq_req = |pending;
        o_irq_high = any_high;
        o_irq_src = win_idx;
        o_irq_vector = is_ext ? ext_vec : base_vec;
    end

    // Assertions
    // Edge flags show one cycle after the first high sample
    sequence conv_rise_s;
        !i_conversion_end ##1 i_conversion_end;
    endsequence

    sequence payload_rise_s;
        !i_radio_payload_ready ##1 i_radio_payload_ready;
    endsequence

    sequence match_rise_s;
        !i_radio_addr_match ##1 i_radio_addr_match;
    endsequence

    clear_loses_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (match_rise && wr_ext_flag && !i_sfr_wdata[7]) |=> extended_flag_reg[7])
        else $error("address-match flag lost to a clear");
    flag_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (extended_flag_reg[6] && !wr_ext_flag) |=> extended_flag_reg[6])
        else $error("extended flag dropped without a write");
    wake_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_wake_event |=> wake_control_reg[3])
        else $error("wakeup event did not set flag");
    global_mask_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !base_enable_reg[7] |-> !o_irq_req)
        else $error("request while globally masked");
    sw_raise_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_ext_flag && i_sfr_wdata[4] && base_enable_reg[7] && extended_enable_reg[0]
         && !wr_base_en && !wr_ext_en) |=> o_irq_req)
        else $error("software set flag did not request");
    reserved_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sfr_addr == ifep_pkg::ADDR_BASE_LEVEL) |-> (o_sfr_rdata[7:6] == 2'b10))
        else $error("reserved level bits wrong");
    conv_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        conv_rise_s |=> extended_flag_reg[4])
        else $error("conversion edge missed");
    level_first_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (pending[0] && !src_level[0] && pend_high == 11'h400) |-> (o_irq_src == 4'hA))
        else $error("high level did not win");
    vector_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_irq_req && o_irq_src == 4'h6) |-> (o_irq_vector == 8'h43))
        else $error("conversion vector wrong");
    match_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        match_rise_s |=> addr_match_flag)
        else $error("address-match edge missed");
    payload_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        payload_rise_s |=> payload_ready_flag)
        else $error("data-ready edge missed");
    shift_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_shift_done |=> shift_done_flag)
        else $error("shift done did not set flag");
    flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_ext_flag && i_sfr_wdata[7]) |=> addr_match_flag)
        else $error("software set of flag lost");
    flag_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_ext_flag && !i_sfr_wdata[6] && !payload_rise) |=> !payload_ready_flag)
        else $error("software clear of flag lost");
    wake_held_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wake_flag && !wr_wake) |=> wake_flag)
        else $error("wakeup flag dropped without a write");
    wake_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_wake && !i_sfr_wdata[3] && !i_wake_event) |=> !wake_flag)
        else $error("wakeup flag clear lost");
    wake_request_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wake_flag && global_mask_bit && wake_irq_enable) |-> o_irq_req)
        else $error("set wakeup flag not requesting");
    timer2_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (global_mask_bit && timer2_irq_enable && i_timer2_external_flag) |-> o_irq_req)
        else $error("timer 2 external flag not requesting");
    timer2_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_irq_req && !timer2_irq_enable) |-> (o_irq_src != 4'h5))
        else $error("disabled timer 2 won");
    uart_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (global_mask_bit && uart_irq_enable && i_uart_rx_done) |-> o_irq_req)
        else $error("serial receive not requesting");
    timer1_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (global_mask_bit && timer1_irq_enable && i_timer1_overflow) |-> o_irq_req)
        else $error("timer 1 overflow not requesting");
    pin1_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (global_mask_bit && pin1_irq_enable && i_ext_pin1_flag) |-> o_irq_req)
        else $error("external pin 1 not requesting");
    pin0_first_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (global_mask_bit && pin0_irq_enable && pin0_irq_level && i_ext_pin0_flag) |-> (o_irq_src == 4'h0))
        else $error("external pin 0 did not win");
    base_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_irq_req && o_irq_src == 4'h5) |-> (o_irq_high == timer2_irq_level))
        else $error("timer 2 level wrong");
    wake_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_irq_req && o_irq_src == 4'hA) |-> (o_irq_high == wake_irq_level))
        else $error("wakeup level wrong");
    wake_vector_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_irq_req && o_irq_src == 4'hA) |-> (o_irq_vector == 8'h63))
        else $error("wakeup vector wrong");
    flag_reserved_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sfr_addr == ifep_pkg::ADDR_EXT_FLAG) |-> (o_sfr_rdata[3:0] == 4'h8))
        else $error("reserved flag bits wrong");
    wake_reserved_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sfr_addr == ifep_pkg::ADDR_WAKE_CTRL) |-> (o_sfr_rdata[6:4] == 3'h4 && o_sfr_rdata[2:0] == 3'h0))
        else $error("reserved wakeup bits wrong");
    level_hit_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sfr_addr == ifep_pkg::ADDR_EXT_LEVEL) |-> o_sfr_hit)
        else $error("mapped address not hit");
endmodule

//--- sim/ifep_src_model.sv
`timescale 1ns/10ps
module ifep_src_model
(
    // Clock
    input wire logic i_clk_sys,
    // Base flags and extended event lines
    output logic [7:0] o_base,
    output logic [4:0] o_evt
);
    initial
    begin
        o_base = 8'h00;
        o_evt = 5'h00;
    end
    // Base flags are levels owned by their units, so they just hold
    task set_base(input logic [7:0] v);
        @(posedge i_clk_sys);
        o_base <= v;
    endtask
    // Event k: 0 conversion, 1 shift, 2 payload, 3 match, 4 wake; line high n cycles then low
    task fire(input int k, input int n);
        @(posedge i_clk_sys);
        o_evt[k] <= 1'b1;
        repeat (n) @(posedge i_clk_sys);
        o_evt[k] <= 1'b0;
    endtask
endmodule

//--- sim/interrupt_flag_enable_priority_bench.sv
`timescale 1ns/10ps
module interrupt_flag_enable_priority_bench;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic [7:0] rdata, base, en_b, lv_b, en_x, lv_x, ef, vec;
    logic [4:0] evt;
    logic hit, req, high, wk;
    logic [3:0] src;
    logic [15:0] r = 16'h0045;
    int n_fail = 0;
    int n_tests = 0;
    localparam logic [7:0] AD [6] = '{8'hA8, 8'hB8, 8'h91, 8'hD8, 8'hE8, 8'hF8};
    localparam logic [7:0] RV [6] = '{8'h00, 8'h80, 8'h08, 8'h40, 8'hE0, 8'hE0};
    localparam logic [7:0] ON [6] = '{8'hBF, 8'hBF, 8'hF8, 8'hC8, 8'hFF, 8'hFF};
    always #50 i_clk_sys = ~i_clk_sys;
    ifep_src_model src_m (.i_clk_sys(i_clk_sys), .o_base(base), .o_evt(evt));
    ifep_ctrl dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
        .i_sfr_wr(wr), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_ext_pin0_flag(base[0]),
        .i_timer0_overflow(base[1]), .i_ext_pin1_flag(base[2]), .i_timer1_overflow(base[3]),
        .i_uart_tx_done(base[4]), .i_uart_rx_done(base[5]), .i_timer2_overflow(base[6]),
        .i_timer2_external_flag(base[7]), .i_conversion_end(evt[0]), .i_shift_done(evt[1]),
        .i_radio_payload_ready(evt[2]), .i_radio_addr_match(evt[3]), .i_wake_event(evt[4]),
        .o_irq_req(req), .o_irq_high(high), .o_irq_src(src), .o_irq_vector(vec));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Lowest natural index wins inside the high level, else inside the low level
    function automatic logic [13:0] exp_irq();
        logic [10:0] act;
        logic [10:0] lv;
        int w;
        act = {wk, ef[7:4], base[7] | base[6], base[5] | base[4], base[3:0]} & {en_x[4:0], en_b[5:0]} & {11{en_b[7]}};
        lv = {lv_x[4:0], lv_b[5:0]};
        w = -1;
        for (int i = 10; i >= 0; i--) if (act[i] && lv[i]) w = i;
        if (w < 0) for (int i = 10; i >= 0; i--) if (act[i]) w = i;
        if (w < 0) return 14'h0000;
        return {1'b1, lv[w], 4'(w), (w < 6) ? 8'h03 + 8'(8 * w) : 8'h43 + 8'(8 * (w - 6))};
    endfunction
    task automatic chk_reg(input string name, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    // Winner fields only mean something while a request stands
    task automatic chk_irq();
        logic [13:0] e;
        e = exp_irq();
        n_tests++;
        if (e[13] ? ({req, high, src, vec} !== e) : (req !== 1'b0))
        begin
            n_fail++;
            $display("mismatch irq expected %h seen %h", e, {req, high, src, vec});
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk_sys);
        wr <= 1'b0;
        case (a)
            8'hA8: en_b = d;
            8'hB8: lv_b = d;
            8'hE8: en_x = d;
            8'hF8: lv_x = d;
            8'h91: ef = d;
            8'hD8: wk = d[3];
        endcase
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        addr <= a;
        @(negedge i_clk_sys);
        chk_reg(n, e, rdata);
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge i_clk_sys);
        n_fail++;
        complete_run();
    end
    initial
    begin
        {en_b, lv_b, en_x, lv_x, ef, wk} = 41'h0;
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 6; k++) rd_chk("reset", AD[k], RV[k]);
        rd_chk("unmapped", 8'h92, 8'h00);
        chk_reg("hit", 8'h00, {7'h0, hit});
        for (int k = 0; k < 6; k++)
        begin
            wr_reg(AD[k], 8'hFF);
            rd_chk("ones", AD[k], ON[k]);
            chk_reg("hit", 8'h01, {7'h0, hit});
        end
        chk_irq();
        for (int k = 0; k < 6; k++)
        begin
            wr_reg(AD[k], 8'h00);
            rd_chk("zeros", AD[k], RV[k]);
        end
        wr_reg(8'hA8, 8'h80);
        wr_reg(8'hE8, 8'h1F);
        for (int k = 0; k < 5; k++)
        begin
            src_m.fire(k, 2);
            repeat (4) @(posedge i_clk_sys);
            rd_chk("hw set", k < 4 ? 8'h91 : 8'hD8, k < 4 ? 8'h08 | (8'h10 << k) : 8'h48);
            if (k < 4) ef[4 + k] = 1'b1;
            else wk = 1'b1;
            chk_irq();
            wr_reg(k < 4 ? 8'h91 : 8'hD8, 8'h00);
            @(negedge i_clk_sys);
            chk_irq();
        end
        fork
            src_m.fire(3, 8);
            begin
                repeat (4) @(posedge i_clk_sys);
                wr_reg(8'h91, 8'h00);
            end
        join
        rd_chk("level held", 8'h91, 8'h08);
        fork
            src_m.fire(1, 1);
            wr_reg(8'h91, 8'h00);
        join
        rd_chk("set wins", 8'h91, 8'h28);
        wr_reg(8'h91, 8'h00);
        repeat (40)
        begin
            r = lfsr(r);
            src_m.set_base(r[7:0]);
            r = lfsr(r);
            wr_reg(8'hA8, r[7:0] | {r[8] | r[9], 7'h00});
            r = lfsr(r);
            wr_reg(8'hB8, r[7:0]);
            r = lfsr(r);
            wr_reg(8'hE8, r[7:0]);
            r = lfsr(r);
            wr_reg(8'hF8, r[7:0]);
            r = lfsr(r);
            wr_reg(8'h91, r[7:0]);
            wr_reg(8'hD8, r[15:8]);
            @(negedge i_clk_sys);
            chk_irq();
        end
        // Reset in mid-run must bring every register back, with base flags left at their last random value
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        {en_b, lv_b, en_x, lv_x, ef, wk} = 41'h0;
        for (int k = 0; k < 6; k++) rd_chk("rerun", AD[k], RV[k]);
        chk_irq();
        complete_run();
    end
endmodule
